// ### verilog/gpf_map.vh
// Register map, field positions and timing counts of the pin function block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef GPF_MAP_VH
`define GPF_MAP_VH

// ============================================================
// Register offsets
`define GPF_OFS_COMPARATOR_STATUS   8'h23
`define GPF_OFS_PIN_CONFIG   8'h24
`define GPF_OFS_DAC_TRIG     8'h21

// ============================================================
// Reset values and write mask
`define GPF_COMPARATOR_STATUS_RST   16'h0000
`define GPF_PIN_CONFIG_RST   16'h0000
`define GPF_PIN_CONFIG_WMASK 16'hBFFF

// ============================================================
// Status bit positions
`define GPF_ST_PROTECT       8
`define GPF_ST_WIN_CH0       7
`define GPF_ST_WIN_CH1       4
`define GPF_ST_CMP_CH0       3
`define GPF_ST_CMP_CH1       0

// ============================================================
// Configuration fields
`define GPF_CF_DEGLITCH      15
`define GPF_CF_OUT_EN        13
`define GPF_CF_OUT_SRC_HI    12
`define GPF_CF_OUT_SRC_LO    9
`define GPF_CF_MASK_HI       8
`define GPF_CF_MASK_LO       5
`define GPF_CF_FUNC_HI       4
`define GPF_CF_FUNC_LO       1
`define GPF_CF_IN_EN         0

// Compare-clear trigger bits in the channel trigger register
`define GPF_TRG_CLR_CH1      15
`define GPF_TRG_CLR_CH0      3

// ============================================================
// Output source codes
`define GPF_SRC_MEM_BUSY     4'h1
`define GPF_SRC_CH1_BUSY     4'h4
`define GPF_SRC_CH0_BUSY     4'h7
`define GPF_SRC_CH1_WIN      4'h8
`define GPF_SRC_CH0_WIN      4'hB

// Input function codes
`define GPF_FN_FAULT_DUMP    4'h2
`define GPF_FN_CURRENT_PDN   4'h3
`define GPF_FN_VOLTAGE_PDN   4'h4
`define GPF_FN_PROTECT       4'h5
`define GPF_FN_CLEAR         4'h7
`define GPF_FN_UPDATE        4'h8
`define GPF_FN_WAVE          4'h9
`define GPF_FN_MARGIN        4'hA
`define GPF_FN_RESET         4'hB
`define GPF_FN_MEM_PROTECT   4'hC
`define GPF_FN_REG_LOCK      4'hD

// Protect modes
`define GPF_PROT_HIZ         2'h0

// ============================================================
// Timing
`define GPF_CLK_MHZ          200
`define GPF_DGL_NS           50
`define GPF_DGL_CYCLES       ((`GPF_DGL_NS * `GPF_CLK_MHZ + 999) / 1000)

`endif

// ### verilog/gpf_deglitch.v
// Deglitch filter for the synchronised pin level.
// Assumes a level already synchronous to ref_clk_in.
`include "gpf_map.vh"
`default_nettype none

module gpf_deglitch (
  // Clock and reset
  input  wire ref_clk_in,
  input  wire srst_in,
  // Level in and filtered level out
  input  wire level_in,
  output wire level_out
);

  localparam [31:0] DGL_LAST_W = (`GPF_DGL_CYCLES) - 1;
  localparam [7:0]  DGL_LAST   = DGL_LAST_W[7:0];

  reg       level_q;
  reg [7:0] cnt_q;

  // ============================================================
  // Filter
  // A new level must persist for the full window before it passes;
  // the price is a fixed extra delay on every edge.
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      level_q <= 1'b1;
      cnt_q   <= 8'h00;
    end else if (level_in == level_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == DGL_LAST) begin
      level_q <= level_in;
      cnt_q   <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign level_out = level_q;

endmodule

`default_nettype wire

// ### verilog/gpf_top.v
// General-purpose pin function logic with comparator status register.
// Assumes a register port from the serial interface logic of the device
// and comparator, busy and protect hand-shake signals from the channels.
`include "gpf_map.vh"
`default_nettype none

module gpf_top (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        srst_in,
  // Register port
  input  wire [7:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  output reg         reg_rvalid_out,
  // Pin
  input  wire        gpio_pin_in,
  output reg         gpio_pin_out,
  output wire        gpio_pin_oe_out,
  // Channel state in, index 0 is channel 0
  input  wire [1:0]  compare_raw_in,
  input  wire [1:0]  window_raw_in,
  input  wire        window_hold_enable_in,
  input  wire [1:0]  channel_busy_in,
  input  wire        memory_program_busy_in,
  input  wire [1:0]  protect_mode_in,
  input  wire        protect_load_done_in,
  // Triggered actions, index 0 is channel 0
  output reg  [1:0]  compare_result_clear_out,
  output reg         fault_dump_out,
  output reg  [1:0]  current_powerdown_out,
  output reg  [1:0]  current_powerup_out,
  output reg  [1:0]  voltage_powerdown_out,
  output reg  [1:0]  voltage_powerup_out,
  output wire        clear_outputs_out,
  output reg  [1:0]  output_update_strobe_out,
  output reg  [1:0]  wave_stop_out,
  output reg  [1:0]  wave_start_out,
  output reg  [1:0]  margin_low_out,
  output reg  [1:0]  margin_high_out,
  output reg         device_reset_out,
  output reg         memory_write_allow_out,
  output reg         register_lock_out,
  // Protect sequence
  output reg         protect_load_out,
  output reg  [1:0]  protect_target_out,
  output reg         protect_powerdown_out
);

  localparam [1:0] P_IDLE = 2'd0;
  localparam [1:0] P_LOAD = 2'd1;
  localparam [1:0] P_WAIT = 2'd2;

  // ============================================================
  // Helpers
  // Mask field to channel vector: mask bit 3 is channel 0
  function [1:0] chan_of_mask;
    input [3:0] mask;
    begin
      chan_of_mask = {mask[0], mask[3]};
    end
  endfunction

  // Known input codes; any other code does nothing
  function fn_valid;
    input [3:0] fn;
    begin
      case (fn)
        `GPF_FN_FAULT_DUMP, `GPF_FN_CURRENT_PDN, `GPF_FN_VOLTAGE_PDN,
        `GPF_FN_PROTECT, `GPF_FN_CLEAR, `GPF_FN_UPDATE, `GPF_FN_WAVE,
        `GPF_FN_MARGIN, `GPF_FN_RESET, `GPF_FN_MEM_PROTECT,
        `GPF_FN_REG_LOCK: fn_valid = 1'b1;
        default:          fn_valid = 1'b0;
      endcase
    end
  endfunction

  reg  [15:0] cfg_q;
  reg         protect_flag_q;
  reg  [1:0]  win_q;
  reg  [1:0]  cmp_meta_q;
  reg  [1:0]  cmp_sync_q;
  reg         pin_meta_q;
  reg         pin_sync_q;
  reg         pin_prev_q;
  reg  [1:0]  prot_state_q;
  wire        pin_filt;
  wire        pin_lvl;
  wire        pin_fall;
  wire        pin_rise;
  wire [3:0]  fn;
  wire [1:0]  chan;
  wire        in_on;
  wire        wr_cfg;
  wire        wr_trig;
  wire        rd_status;
  wire [1:0]  cmp_clr;
  wire        protect_go;
  wire [15:0] status;

  // ============================================================
  // Register port
  assign wr_cfg    = reg_wr_in && (reg_addr_in == `GPF_OFS_PIN_CONFIG)
                     && !register_lock_out;
  // The lock covers the trigger register as well, not only the config
  assign wr_trig   = reg_wr_in && (reg_addr_in == `GPF_OFS_DAC_TRIG)
                     && !register_lock_out;
  assign rd_status = reg_rd_in && (reg_addr_in == `GPF_OFS_COMPARATOR_STATUS);
  assign cmp_clr   = wr_trig ? {reg_wdata_in[`GPF_TRG_CLR_CH1],
                                reg_wdata_in[`GPF_TRG_CLR_CH0]} : 2'b00;

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg_q <= `GPF_PIN_CONFIG_RST;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata_in & `GPF_PIN_CONFIG_WMASK;
    end
  end

  assign status = {7'h00, protect_flag_q, win_q[0], 2'b00, win_q[1],
                   cmp_sync_q[0], 2'b00, cmp_sync_q[1]};

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      reg_rdata_out  <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (!reg_rd_in) begin
        reg_rdata_out <= reg_rdata_out;
      end else if (reg_addr_in == `GPF_OFS_COMPARATOR_STATUS) begin
        reg_rdata_out <= status;
      end else if (reg_addr_in == `GPF_OFS_PIN_CONFIG) begin
        reg_rdata_out <= cfg_q;
      end else begin
        reg_rdata_out <= 16'h0000;
      end
    end
  end

  // ============================================================
  // Comparator results
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      cmp_meta_q <= 2'b00;
      cmp_sync_q <= 2'b00;
      win_q      <= 2'b00;
      compare_result_clear_out <= 2'b00;
    end else begin
      cmp_meta_q <= compare_raw_in;
      cmp_sync_q <= cmp_meta_q;
      // Self-clearing trigger: a one-cycle pulse per write
      compare_result_clear_out <= cmp_clr;
      if (window_hold_enable_in) begin
        // A new result in the clearing cycle is kept
        win_q <= window_raw_in | (win_q & ~cmp_clr);
      end else begin
        win_q <= window_raw_in;
      end
    end
  end

  // ============================================================
  // Pin output
  assign gpio_pin_oe_out = cfg_q[`GPF_CF_OUT_EN];

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      gpio_pin_out <= 1'b0;
    end else begin
      case (cfg_q[`GPF_CF_OUT_SRC_HI:`GPF_CF_OUT_SRC_LO])
        `GPF_SRC_MEM_BUSY: gpio_pin_out <= memory_program_busy_in;
        `GPF_SRC_CH1_BUSY: gpio_pin_out <= channel_busy_in[1];
        `GPF_SRC_CH0_BUSY: gpio_pin_out <= channel_busy_in[0];
        `GPF_SRC_CH1_WIN:  gpio_pin_out <= win_q[1];
        `GPF_SRC_CH0_WIN:  gpio_pin_out <= win_q[0];
        default:           gpio_pin_out <= 1'b0;
      endcase
    end
  end

  // ============================================================
  // Pin input path
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= gpio_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_lvl;
    end
  end

  gpf_deglitch u_deglitch (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .level_in   (pin_sync_q),
    .level_out  (pin_filt)
  );

  assign pin_lvl  = cfg_q[`GPF_CF_DEGLITCH] ? pin_filt : pin_sync_q;
  assign in_on    = cfg_q[`GPF_CF_IN_EN];
  assign fn       = cfg_q[`GPF_CF_FUNC_HI:`GPF_CF_FUNC_LO];
  assign chan     = chan_of_mask(cfg_q[`GPF_CF_MASK_HI:`GPF_CF_MASK_LO]);
  // Edges are judged on consecutive samples, so each edge fires once
  assign pin_fall = in_on && fn_valid(fn) && pin_prev_q && !pin_lvl;
  assign pin_rise = in_on && fn_valid(fn) && !pin_prev_q && pin_lvl;

  assign clear_outputs_out = in_on && (fn == `GPF_FN_CLEAR)
                             && !pin_lvl;
  assign protect_go = pin_fall && (fn == `GPF_FN_PROTECT);

  // ============================================================
  // Edge-triggered functions
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      fault_dump_out           <= 1'b0;
      current_powerdown_out    <= 2'b00;
      current_powerup_out      <= 2'b00;
      voltage_powerdown_out    <= 2'b00;
      voltage_powerup_out      <= 2'b00;
      output_update_strobe_out <= 2'b00;
      wave_stop_out            <= 2'b00;
      wave_start_out           <= 2'b00;
      margin_low_out           <= 2'b00;
      margin_high_out          <= 2'b00;
      device_reset_out         <= 1'b0;
      memory_write_allow_out   <= 1'b0;
      register_lock_out        <= 1'b0;
    end else begin
      fault_dump_out <= pin_fall && (fn == `GPF_FN_FAULT_DUMP);
      current_powerdown_out <=
        (pin_fall && fn == `GPF_FN_CURRENT_PDN) ? chan : 2'b00;
      current_powerup_out <=
        (pin_rise && fn == `GPF_FN_CURRENT_PDN) ? chan : 2'b00;
      voltage_powerdown_out <=
        (pin_fall && fn == `GPF_FN_VOLTAGE_PDN) ? chan : 2'b00;
      voltage_powerup_out <=
        (pin_rise && fn == `GPF_FN_VOLTAGE_PDN) ? chan : 2'b00;
      output_update_strobe_out <=
        (pin_fall && fn == `GPF_FN_UPDATE) ? chan : 2'b00;
      wave_stop_out <=
        (pin_fall && fn == `GPF_FN_WAVE) ? chan : 2'b00;
      wave_start_out <=
        (pin_rise && fn == `GPF_FN_WAVE) ? chan : 2'b00;
      margin_low_out <=
        (pin_fall && fn == `GPF_FN_MARGIN) ? chan : 2'b00;
      margin_high_out <=
        (pin_rise && fn == `GPF_FN_MARGIN) ? chan : 2'b00;
      if (fn == `GPF_FN_RESET) begin
        if (pin_fall) begin
          device_reset_out <= 1'b1;
        end else if (pin_rise) begin
          device_reset_out <= 1'b0;
        end
      end
      if (fn == `GPF_FN_MEM_PROTECT) begin
        if (pin_fall) begin
          memory_write_allow_out <= 1'b1;
        end else if (pin_rise) begin
          memory_write_allow_out <= 1'b0;
        end
      end
      if (fn == `GPF_FN_REG_LOCK) begin
        if (pin_fall) begin
          register_lock_out <= 1'b0;
        end else if (pin_rise) begin
          register_lock_out <= 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Protect sequence
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      prot_state_q          <= P_IDLE;
      protect_load_out      <= 1'b0;
      protect_target_out    <= 2'b00;
      protect_powerdown_out <= 1'b0;
    end else begin
      protect_load_out      <= 1'b0;
      protect_powerdown_out <= 1'b0;
      case (prot_state_q)
        P_IDLE: begin
          if (protect_go) begin
            protect_target_out <= protect_mode_in;
            if (protect_mode_in == `GPF_PROT_HIZ) begin
              protect_powerdown_out <= 1'b1;
            end else begin
              prot_state_q <= P_LOAD;
            end
          end
        end
        P_LOAD: begin
          protect_load_out <= 1'b1;
          prot_state_q     <= P_WAIT;
        end
        P_WAIT: begin
          // Power-down waits for the preload or slew to finish
          if (protect_load_done_in) begin
            protect_powerdown_out <= 1'b1;
            prot_state_q          <= P_IDLE;
          end
        end
        default: begin
          prot_state_q <= P_IDLE;
        end
      endcase
    end
  end

  // Set wins over the read that clears it
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      protect_flag_q <= 1'b0;
    end else if (protect_go || prot_state_q != P_IDLE) begin
      protect_flag_q <= 1'b1;
    end else if (rd_status) begin
      protect_flag_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### tb/gpf_pin_peer.sv
// Peer model: outside logic that drives the shared pin.
// Assumes the design's output enable is high while it drives the pin.
`default_nettype none

module gpf_pin_peer (
  // Clock
  input  wire logic ref_clk_in,
  // Design side of the pin
  input  wire logic dut_drive_in,
  input  wire logic dut_oe_in,
  // Resolved pin level
  output wire logic pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_q = 1'b0;
  logic lvl_q = 1'b1;

  // An undriven pin sits at the pull-up, never at the last driven level
  assign pin_level_out = dut_oe_in ? dut_drive_in : (drv_q ? lvl_q : 1'b1);

  task automatic drive(input logic v);
    @(posedge ref_clk_in);
    drv_q <= 1'b1;
    lvl_q <= v;
  endtask

  // Low pulse of n cycles, as the glitch tests need
  task automatic pulse(input int n);
    drive(1'b0);
    repeat (n) @(posedge ref_clk_in);
    lvl_q <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb/gpf_top_sva.sv
// Checker for the pin function block, bound to its top module.
// Assumes only the top-level ports of the block are visible.
`default_nettype none

module gpf_top_sva (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_rdata_out,
  input  wire logic        reg_rvalid_out,
  // Watched outputs
  input  wire logic        gpio_pin_oe_out,
  input  wire logic [1:0]  compare_result_clear_out,
  input  wire logic        fault_dump_out,
  input  wire logic        register_lock_out,
  input  wire logic        device_reset_out,
  input  wire logic        protect_load_out,
  input  wire logic [1:0]  protect_target_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // ==========
  // Properties
  read_answer_a: assert property ((reg_rd_in |=> reg_rvalid_out) and
    (!reg_rd_in |=> !reg_rvalid_out)) else $error("read answer wrong");
  status_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h23
    |=> (reg_rdata_out & 16'hFE66) == 16'h0000) else $error("status bits");
  clr_pulse_a: assert property (reg_wr_in && reg_addr_in == 8'h21 |=>
    compare_result_clear_out == ($past(register_lock_out) ? 2'h0 :
    {$past(reg_wdata_in[15]), $past(reg_wdata_in[3])}))
    else $error("compare clear pulse");
  clr_cause_a: assert property (compare_result_clear_out != 2'h0
    |-> $past(reg_wr_in && reg_addr_in == 8'h21 && !register_lock_out))
    else $error("stray clear");
  oe_cause_a: assert property ($rose(gpio_pin_oe_out) |-> $past(reg_wr_in
    && reg_addr_in == 8'h24 && reg_wdata_in[13] && !register_lock_out))
    else $error("output enable rose without write");
  prot_load_a: assert property ($rose(protect_load_out) |->
    protect_target_out != 2'h0 ##1 !protect_load_out)
    else $error("protect preload wrong");
  reset_idle_a: assert property ($fell(srst_in) |-> !gpio_pin_oe_out &&
    !register_lock_out && !device_reset_out && !reg_rvalid_out)
    else $error("outputs not idle after reset");
  dump_once_a: assert property (fault_dump_out |=> !fault_dump_out)
    else $error("fault dump longer than one cycle");
endmodule

bind gpf_top gpf_top_sva u_gpf_top_sva (.*);
`default_nettype wire

// ### tb/tb_gpf_top.sv
// Testbench for the pin function block: register and pin scenarios.
// Assumes the peer model and the bound checker are compiled first.
`default_nettype none
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, v); end end

module tb_gpf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic        ref_clk_in, srst_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic        gpio_pin_in, gpio_pin_out, gpio_pin_oe_out;
  logic [1:0]  compare_raw_in, window_raw_in, channel_busy_in;
  logic        window_hold_enable_in, memory_program_busy_in;
  logic [1:0]  protect_mode_in, protect_target_out, compare_result_clear_out;
  logic        protect_load_done_in, protect_load_out, protect_powerdown_out;
  logic [1:0]  current_powerdown_out, current_powerup_out;
  logic [1:0]  voltage_powerdown_out, voltage_powerup_out, margin_high_out;
  logic [1:0]  output_update_strobe_out, wave_stop_out, wave_start_out;
  logic [1:0]  margin_low_out;
  logic        fault_dump_out, clear_outputs_out, device_reset_out;
  logic        memory_write_allow_out, register_lock_out, clr;
  logic [19:0] seen;
  logic [23:0] snap;
  int          errors, comparisons;
  logic [3:0]  sc [5] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hB};
  int          sp [5] = '{0, 2, 1, 4, 3};

  gpf_top u_gpf_top (.*);
  gpf_pin_peer u_gpf_pin_peer (.ref_clk_in, .dut_drive_in(gpio_pin_out),
    .dut_oe_in(gpio_pin_oe_out), .pin_level_out(gpio_pin_in));

  // Pulses are one cycle wide, so they are gathered into sticky bits
  always @(posedge ref_clk_in) begin
    if (clr)
      seen <= '0;
    else
      seen <= seen | {fault_dump_out, current_powerdown_out,
        current_powerup_out, voltage_powerdown_out, voltage_powerup_out,
        output_update_strobe_out, wave_stop_out, wave_start_out,
        margin_low_out, margin_high_out, protect_powerdown_out};
  end
  assign snap = {clear_outputs_out, device_reset_out, memory_write_allow_out,
    register_lock_out, seen};

  // ==========
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid_out)
    `CHK("rdata", e, reg_rdata_out)
    // Back onto the edge so later stimulus is clocked in by NBA
    @(posedge ref_clk_in);
  endtask
  task automatic arm(input logic [15:0] c);
    wr(8'h24, c);
    clr <= 1'b1;
    cyc(4);
    clr <= 1'b0;
  endtask
  task automatic run_fn(input logic [15:0] c, input logic [23:0] f, r);
    arm(c);
    u_gpf_pin_peer.drive(1'b0);
    cyc(20);
    `CHK("fall", f, snap)
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    u_gpf_pin_peer.drive(1'b1);
    cyc(20);
    `CHK("rise", r, snap)
  endtask
  task automatic glitch(input logic [15:0] c, input logic [23:0] e);
    arm(c);
    u_gpf_pin_peer.pulse(3);
    cyc(20);
    `CHK("glitch", e, snap)
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========
  // Clock, watchdog and tests
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    cyc(20000);
    errors++;
    stop_test();
  end
  initial begin
    srst_in = 1'b1;
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in, clr} = '0;
    {compare_raw_in, window_raw_in, channel_busy_in} = '0;
    {window_hold_enable_in, memory_program_busy_in} = '0;
    {protect_mode_in, protect_load_done_in} = '0;
    cyc(10);
    srst_in <= 1'b0;
    rd(8'h23, 16'h0000);
    rd(8'h24, 16'h0000);
    rd(8'h30, 16'h0000);
    wr(8'h24, 16'hFFFF);
    rd(8'h24, 16'hBFFF);
    compare_raw_in <= 2'b01;
    cyc(4);
    rd(8'h23, 16'h0008);
    compare_raw_in <= 2'b10;
    cyc(4);
    rd(8'h23, 16'h0001);
    compare_raw_in <= 2'b00;
    window_hold_enable_in <= 1'b1;
    window_raw_in <= 2'b11;
    cyc(4);
    window_raw_in <= 2'b00;
    cyc(4);
    rd(8'h23, 16'h0090);
    wr(8'h21, 16'h0008);
    rd(8'h23, 16'h0010);
    wr(8'h21, 16'h8000);
    rd(8'h23, 16'h0000);
    window_hold_enable_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(8'h24, 16'h2000 | {3'h0, sc[i], 9'h000});
      {window_raw_in, channel_busy_in, memory_program_busy_in} <=
        5'h01 << sp[i];
      cyc(6);
      `CHK("pin_high", 1'b1, gpio_pin_in)
      {window_raw_in, channel_busy_in, memory_program_busy_in} <=
        ~(5'h01 << sp[i]);
      cyc(6);
      `CHK("pin_low", 1'b0, gpio_pin_in)
    end
    `CHK("oe_on", 1'b1, gpio_pin_oe_out)
    {window_raw_in, channel_busy_in, memory_program_busy_in} <= 5'h00;
    wr(8'h24, 16'h0000);
    cyc(2);
    `CHK("oe_off", 1'b0, gpio_pin_oe_out)
    u_gpf_pin_peer.drive(1'b1);
    cyc(4);
    run_fn(16'h0124, 24'h000000, 24'h000000);
    run_fn(16'h012D, 24'h000000, 24'h000000);
    run_fn(16'h0125, 24'h080000, 24'h000000);
    run_fn(16'h0127, 24'h060000, 24'h018000);
    run_fn(16'h0107, 24'h020000, 24'h008000);
    run_fn(16'h0129, 24'h006000, 24'h001800);
    run_fn(16'h012B, 24'h000001, 24'h000000);
    rd(8'h23, 16'h0100);
    rd(8'h23, 16'h0000);
    protect_mode_in <= 2'h1;
    protect_load_done_in <= 1'b1;
    run_fn(16'h012B, 24'h000001, 24'h000000);
    rd(8'h23, 16'h0100);
    run_fn(16'h012F, 24'h800000, 24'h000000);
    run_fn(16'h0131, 24'h000600, 24'h000000);
    run_fn(16'h8131, 24'h000600, 24'h000000);
    run_fn(16'h0133, 24'h000180, 24'h000060);
    run_fn(16'h0033, 24'h000100, 24'h000040);
    run_fn(16'h0135, 24'h000018, 24'h000006);
    run_fn(16'h0137, 24'h400000, 24'h000000);
    run_fn(16'h0139, 24'h200000, 24'h000000);
    glitch(16'h8131, 24'h000000);
    glitch(16'h0131, 24'h000600);
    run_fn(16'h013B, 24'h000000, 24'h100000);
    wr(8'h24, 16'h0000);
    rd(8'h24, 16'h013B);
    wr(8'h21, 16'h8008);
    u_gpf_pin_peer.drive(1'b0);
    cyc(8);
    `CHK("unlock", 1'b0, register_lock_out)
    stop_test();
  end
endmodule
`default_nettype wire
